// File: swh_defs.svh
// constants for the single-wire otp host: command codes, memory limits, timing
// assumes a 50 MHz system clock; times are the figures, counts derive in the module
`ifndef SWH_DEFS_SVH
`define SWH_DEFS_SVH
`define SWH_CMD_READ_ID   8'h33
`define SWH_CMD_SKIP_ID   8'hcc
`define SWH_CMD_PAGE_RD   8'hc3
`define SWH_CMD_FIELD_RD  8'hf0
`define SWH_CMD_WRITE     8'h0f
`define SWH_CMD_PROGRAM   8'h5a
`define SWH_CRC_POLY_REF  8'h8c
`define SWH_MEM_LAST      7'h7f
`define SWH_PAGE_LAST     5'h1f
`define SWH_ID_LAST       3'h7
`define SWH_CLK_NS        20
`define SWH_T_RST_US      480
`define SWH_T_PROG_US     2500
`define SWH_T_LOW0_NS     60000
`define SWH_T_LOW1_NS     6000
`define SWH_T_SAMP_NS     15000
`define SWH_T_SLOT_NS     70000
`define SWH_T_PRES_NS     70000
`endif

// File: swh_pkg.sv
// types for the single-wire otp host: operations and port carriers
// assumes swh_defs.svh supplies the numeric constants
package swh_pkg;
  typedef enum logic [1:0] {OP_READ_ID, OP_PAGE_READ, OP_FIELD_READ, OP_WRITE} swh_op_e;
  typedef struct packed {
    logic        valid;
    swh_op_e     op;
    logic [6:0]  addr;
    logic [63:0] wdata;
  } swh_req_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } swh_rd_s;
  typedef struct packed {
    logic done;
    logic crc_fail;
    logic no_presence;
  } swh_sts_s;
endpackage

// File: swh_host.sv
// host controller for a single-wire line-powered otp memory
// assumes an external pull-up on the line and a vpp switch driven by VPP_EN
`include "swh_defs.svh"

// How it works
// - every transaction opens with the line held low at least 480 us.
// - identity read sends 33h, then reads family, serial and crc bytes.
// - skip-identity CCh directly precedes every memory function command.
// - page read sends C3h, address low byte, address high byte.
// - a crc mismatch causes a fresh reset and full sequence restart, except the RETRIES-th, which ends the request with crc_fail.
// - field read sends F0h, address low byte, address high byte.
// - address and data bytes go least significant bit first.
// - write sends 0Fh, address bytes, then reads and checks address crc.
// - write sends eight data bytes, then reads and checks their crc.
// - on good data crc, host sends 5Ah and applies vpp at least 2500 us.
// - write start address forced to a multiple of eight within 00..7f.
// - no reset is issued while the programming pulse is applied.
// - host alone decides to continue after comparing crcs.
// - crc is x^8+x^5+x^4+1, shifted lsb first.
module swh_host #(
  parameter int RST_CYC  = `SWH_T_RST_US * 1000 / `SWH_CLK_NS,
  parameter int PROG_CYC = `SWH_T_PROG_US * 1000 / `SWH_CLK_NS,
  parameter int RETRIES  = 3,
  parameter int LOW0_CYC = (`SWH_T_LOW0_NS + `SWH_CLK_NS - 1) / `SWH_CLK_NS,
  parameter int LOW1_CYC = (`SWH_T_LOW1_NS + `SWH_CLK_NS - 1) / `SWH_CLK_NS,
  parameter int SAMP_CYC = `SWH_T_SAMP_NS / `SWH_CLK_NS,
  parameter int SLOT_CYC = (`SWH_T_SLOT_NS + `SWH_CLK_NS - 1) / `SWH_CLK_NS,
  parameter int PRES_CYC = `SWH_T_PRES_NS / `SWH_CLK_NS
) (
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire swh_pkg::swh_req_s REQ,
  output logic                  REQ_READY,
  output swh_pkg::swh_rd_s      RD,
  output swh_pkg::swh_sts_s     STS,
  input  wire logic             DQ_IN,
  output logic                  DQ_OUT,
  output logic                  DQ_OE,
  output logic                  VPP_EN
);
  import swh_pkg::*;

  localparam int TW       = 18;

  typedef enum logic [2:0] {ST_IDLE, ST_RST, ST_PRES, ST_SLOT, ST_PROG} swh_state_e;
  typedef enum logic [3:0] {PH_ROM, PH_FUNC, PH_ALO, PH_AHI, PH_ACRC, PH_RDATA, PH_DCRC,
                            PH_ID, PH_WDATA, PH_WCRC, PH_PCMD} swh_phase_e;

  // lsb-first crc step, reflected polynomial
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ b[i]) != 1'b0) ? ((r >> 1) ^ `SWH_CRC_POLY_REF) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic is_rx(input swh_phase_e p);
    return p inside {PH_ACRC, PH_RDATA, PH_DCRC, PH_ID, PH_WCRC};
  endfunction

  swh_state_e  state_reg, state_next;
  swh_phase_e  phase_reg, phase_next;
  swh_op_e     op_reg, op_next;
  logic [TW-1:0] t_reg, t_next;
  logic [2:0]  bit_reg, bit_next, cnt_reg, cnt_next;
  logic [7:0]  tx_reg, tx_next, rx_reg, rx_next, crc_reg, crc_next;
  logic [6:0]  addr_reg, addr_next, start_reg, start_next;
  logic [63:0] wdata_reg, wdata_next;
  // second copy of the write data so a retry can resend it
  logic [63:0] wsave_reg, wsave_next;
  logic [1:0]  try_reg, try_next;
  logic        oe_reg, oe_next, vpp_reg, vpp_next, rdy_reg, rdy_next;
  swh_rd_s     rd_reg, rd_next;
  swh_sts_s    sts_reg, sts_next;
  logic        dq_meta, dq_s;

  // line is asynchronous to CLK: two flops before use
  always_ff @(posedge CLK) begin
    dq_meta <= DQ_IN;
    dq_s    <= dq_meta;
  end

  always_comb begin
    logic [7:0] byte_v;
    logic [7:0] crc_u;
    logic       fail;
    logic       lo_one;
    state_next = state_reg;
    phase_next = phase_reg;
    op_next    = op_reg;
    t_next     = t_reg + TW'(1);
    bit_next   = bit_reg;
    cnt_next   = cnt_reg;
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    crc_next   = crc_reg;
    addr_next  = addr_reg;
    start_next = start_reg;
    wdata_next = wdata_reg;
    wsave_next = wsave_reg;
    try_next   = try_reg;
    oe_next    = 1'b0;
    vpp_next   = 1'b0;
    rdy_next   = 1'b0;
    rd_next    = '0;
    sts_next   = '0;
    sts_next.no_presence = sts_reg.no_presence;
    byte_v = is_rx(phase_reg) ? rx_reg : tx_reg;
    crc_u  = crc8(crc_reg, byte_v);
    fail   = 1'b0;
    lo_one = is_rx(phase_reg) || tx_reg[bit_reg];
    case (state_reg)
      ST_IDLE: begin
        rdy_next   = 1'b1;
        t_next     = '0;
        wsave_next = REQ.wdata;
        if (REQ.valid && rdy_reg) begin
          rdy_next  = 1'b0;
          op_next   = REQ.op;
          // writes only on aligned 8-byte segments
          start_next = (REQ.op == OP_WRITE) ? {REQ.addr[6:3], 3'h0} : REQ.addr;
          addr_next = start_next;
          wdata_next = REQ.wdata;
          try_next  = '0;
          sts_next.no_presence = 1'b0;
          state_next = ST_RST;
        end
      end
      ST_RST: begin
        oe_next = 1'b1;
        if (t_reg == TW'(RST_CYC)) begin
          oe_next    = 1'b0;
          t_next     = '0;
          state_next = ST_PRES;
        end
      end
      ST_PRES: begin
        // device pulls low after release
        if (t_reg == TW'(PRES_CYC) && dq_s) begin
          sts_next.no_presence = 1'b1;
          sts_next.done        = 1'b1;
          state_next           = ST_IDLE;
        end else if (t_reg == TW'(RST_CYC - 1)) begin
          t_next     = '0;
          bit_next   = '0;
          phase_next = PH_ROM;
          tx_next    = (op_reg == OP_READ_ID) ? `SWH_CMD_READ_ID : `SWH_CMD_SKIP_ID;
          state_next = ST_SLOT;
        end
      end
      ST_SLOT: begin
        // short low for one or read, long low for zero
        oe_next = (t_reg < TW'(lo_one ? LOW1_CYC : LOW0_CYC));
        if (t_reg == TW'(SAMP_CYC) && is_rx(phase_reg)) begin
          rx_next = {dq_s, rx_reg[7:1]};
        end
        if (t_reg == TW'(SLOT_CYC - 1)) begin
          t_next   = '0;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            case (phase_reg)
              PH_ROM: begin
                crc_next = '0;
                cnt_next = '0;
                if (op_reg == OP_READ_ID) begin
                  phase_next = PH_ID;
                end else begin
                  phase_next = PH_FUNC;
                  tx_next = (op_reg == OP_PAGE_READ)  ? `SWH_CMD_PAGE_RD :
                            (op_reg == OP_FIELD_READ) ? `SWH_CMD_FIELD_RD :
                                                        `SWH_CMD_WRITE;
                end
              end
              PH_FUNC: begin
                crc_next   = crc_u;
                phase_next = PH_ALO;
                tx_next    = {1'b0, start_reg};
              end
              PH_ALO: begin
                crc_next   = crc_u;
                phase_next = PH_AHI;
                tx_next    = 8'h00;
              end
              PH_AHI: begin
                crc_next   = crc_u;
                phase_next = PH_ACRC;
              end
              PH_ACRC: begin
                fail     = (rx_reg != crc_reg);
                crc_next = '0;
                cnt_next = '0;
                if (op_reg == OP_WRITE) begin
                  phase_next = PH_WDATA;
                  tx_next    = wdata_reg[7:0];
                end else begin
                  phase_next = PH_RDATA;
                end
              end
              PH_RDATA: begin
                rd_next   = '{valid: 1'b1, data: rx_reg};
                crc_next  = crc_u;
                addr_next = addr_reg + 7'h1;
                if (addr_reg == `SWH_MEM_LAST ||
                    (op_reg == OP_PAGE_READ && addr_reg[4:0] == `SWH_PAGE_LAST)) begin
                  phase_next = PH_DCRC;
                end
              end
              PH_DCRC: begin
                fail       = (rx_reg != crc_reg);
                crc_next   = '0;
                phase_next = PH_RDATA;
                // address wrapped: memory end reached, later slots are ones
                if (!fail && addr_reg == 7'h00) begin
                  sts_next.done = 1'b1;
                  state_next    = ST_IDLE;
                end
              end
              PH_ID: begin
                rd_next  = '{valid: 1'b1, data: rx_reg};
                crc_next = crc_u;
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == `SWH_ID_LAST) begin
                  // crc over all eight bytes ends at zero when intact
                  fail = (crc_u != 8'h00);
                  if (!fail) begin
                    sts_next.done = 1'b1;
                    state_next    = ST_IDLE;
                  end
                end
              end
              PH_WDATA: begin
                crc_next   = crc_u;
                cnt_next   = cnt_reg + 3'h1;
                wdata_next = {8'h00, wdata_reg[63:8]};
                tx_next    = wdata_reg[15:8];
                if (cnt_reg == 3'h7) begin
                  phase_next = PH_WCRC;
                end
              end
              PH_WCRC: begin
                fail       = (rx_reg != crc_reg);
                phase_next = PH_PCMD;
                tx_next    = `SWH_CMD_PROGRAM;
              end
              default: begin
                // program code sent: line released, vpp applied
                t_next     = '0;
                vpp_next   = 1'b1;
                state_next = ST_PROG;
              end
            endcase
            if (fail) begin
              // restart from reset; bytes already streamed come again
              t_next     = '0;
              addr_next  = start_reg;
              wdata_next = wsave_reg;
              if (try_reg == 2'(RETRIES - 1)) begin
                sts_next.crc_fail = 1'b1;
                sts_next.done     = 1'b1;
                state_next        = ST_IDLE;
              end else begin
                try_next   = try_reg + 2'h1;
                state_next = ST_RST;
              end
            end
          end
        end
      end
      default: begin
        // no reset may cut into the pulse, so nothing aborts this wait
        vpp_next = 1'b1;
        if (t_reg == TW'(PROG_CYC - 1)) begin
          vpp_next      = 1'b0;
          sts_next.done = 1'b1;
          state_next    = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ROM;
      op_reg    <= OP_READ_ID;
      t_reg     <= '0;
      bit_reg   <= '0;
      cnt_reg   <= '0;
      tx_reg    <= '0;
      rx_reg    <= '0;
      crc_reg   <= '0;
      addr_reg  <= '0;
      start_reg <= '0;
      wdata_reg <= '0;
      wsave_reg <= '0;
      try_reg   <= '0;
      oe_reg    <= 1'b0;
      vpp_reg   <= 1'b0;
      rdy_reg   <= 1'b0;
      rd_reg    <= '0;
      sts_reg   <= '0;
      DQ_OUT    <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      op_reg    <= op_next;
      t_reg     <= t_next;
      bit_reg   <= bit_next;
      cnt_reg   <= cnt_next;
      tx_reg    <= tx_next;
      rx_reg    <= rx_next;
      crc_reg   <= crc_next;
      addr_reg  <= addr_next;
      start_reg <= start_next;
      wdata_reg <= wdata_next;
      wsave_reg <= wsave_next;
      try_reg   <= try_next;
      oe_reg    <= oe_next;
      vpp_reg   <= vpp_next;
      rdy_reg   <= rdy_next;
      rd_reg    <= rd_next;
      sts_reg   <= sts_next;
      DQ_OUT    <= 1'b0;
    end
  end

  assign REQ_READY = rdy_reg;
  assign RD        = rd_reg;
  assign STS       = sts_reg;
  assign DQ_OE     = oe_reg;
  assign VPP_EN    = vpp_reg;
endmodule

// File: swh_host_monitor.sv
// checker on the single-wire otp host ports
// assumes swh_pkg is compiled first; bound into swh_host at the foot
module swh_host_monitor #(
  parameter int RST_CYC  = 24000,
  parameter int PROG_CYC = 125000,
  parameter int LOW0_CYC = 3000,
  parameter int LOW1_CYC = 300
) (
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire swh_pkg::swh_req_s REQ,
  input wire logic              REQ_READY,
  input wire swh_pkg::swh_rd_s  RD,
  input wire swh_pkg::swh_sts_s STS,
  input wire logic              DQ_IN,
  input wire logic              DQ_OUT,
  input wire logic              DQ_OE,
  input wire logic              VPP_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  import swh_pkg::*;
  int   oe_run;
  int   vpp_run;
  logic in_rst;
  // run lengths of the low drive and of the vpp window
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      oe_run  <= 0;
      vpp_run <= 0;
      in_rst  <= 1'b0;
    end else begin
      oe_run  <= DQ_OE ? oe_run + 1 : 0;
      vpp_run <= VPP_EN ? vpp_run + 1 : 0;
      in_rst  <= (REQ.valid && REQ_READY) || (in_rst && !$fell(DQ_OE));
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  chk_take_resets: assert property (REQ.valid && REQ_READY |-> ##[1:3] DQ_OE)
    else $error("line not pulled low after a take");
  chk_reset_long: assert property ($fell(DQ_OE) && in_rst |-> oe_run >= RST_CYC)
    else $error("opening reset too short");
  chk_slot_shape: assert property ($fell(DQ_OE) |->
                                   oe_run inside {LOW1_CYC, LOW0_CYC} || oe_run >= RST_CYC)
    else $error("low drive of unexpected length");
  chk_prog_min: assert property ($fell(VPP_EN) |-> vpp_run >= PROG_CYC)
    else $error("program pulse too short");
  chk_prog_bound: assert property (VPP_EN |-> vpp_run < PROG_CYC + 4)
    else $error("program pulse overlong");
  chk_prog_no_reset: assert property (VPP_EN |-> !DQ_OE)
    else $error("line pulled low during program pulse");
  chk_fail_done: assert property (STS.crc_fail |-> STS.done)
    else $error("crc failure without done");
  chk_read_busy: assert property (RD.valid |-> !REQ_READY)
    else $error("read byte while idle");
endmodule

bind swh_host swh_host_monitor #(.RST_CYC(RST_CYC), .PROG_CYC(PROG_CYC),
  .LOW0_CYC(LOW0_CYC), .LOW1_CYC(LOW1_CYC)) mon_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .REQ(REQ), .REQ_READY(REQ_READY), .RD(RD), .STS(STS),
  .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .VPP_EN(VPP_EN));

// File: swh_dev_model.sv
// behavioural single-wire otp memory facing the host under test
// assumes the bench resolves the line with a pull-up; clk only paces waits
package swh_vpkg;
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction
endpackage

module swh_dev_model
  import swh_vpkg::*;
#(
  parameter logic [7:0]  FAMILY  = 8'h5e,          // arbitrary value
  parameter logic [47:0] SERIAL  = 48'h2a7d13c04e91,
  parameter int          RST_MIN   = 4000,
  parameter int          PRES_WAIT = 1000,
  parameter int          PRES_LEN  = 3000,
  parameter int          BIT_WAIT  = 1500
) (
  input  wire logic clk,
  input  wire logic line,
  input  wire logic vpp,
  output logic      pull_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [128];
  logic [7:0]  rom [8];
  logic [55:0] idw = {SERIAL, FAMILY};
  logic [3:0]  wp_ok = 4'hf;  // protect bits erased: all pages writable
  int          low_cnt = 0;
  int          bad_left = 0;  // sessions whose address crc is spoiled
  event        rst_ev;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    rom[7] = 8'h00;
    for (int i = 0; i < 7; i++) begin
      rom[i] = idw[8*i +: 8];
      rom[7] = crc8(rom[7], rom[i]);
    end
  end
  // must exceed the longest slot low time, or a zero bit would reset us
  always @(posedge clk) begin
    low_cnt <= line ? 0 : low_cnt + 1;
    if (low_cnt == RST_MIN) ->rst_ev;
  end
  task automatic get_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge line);
      repeat (BIT_WAIT) @(posedge clk);
      v[i] = line;
    end
  endtask
  task automatic put_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge line);
      pull_low = !v[i];
      repeat (BIT_WAIT) @(posedge clk);
      pull_low = 1'b0;
    end
  endtask
  task automatic session();
    logic [7:0] c, al, ah, crc;
    logic [7:0] buf8 [8];
    int         a;
    wait (line);
    repeat (PRES_WAIT) @(posedge clk);
    pull_low = 1'b1;
    repeat (PRES_LEN) @(posedge clk);
    pull_low = 1'b0;
    get_byte(c);
    if (c == 8'h33) begin
      for (int i = 0; i < 8; i++) put_byte(rom[i]);
    end else if (c == 8'hcc) begin
      get_byte(c);
      get_byte(al);
      get_byte(ah);
      crc = crc8(crc8(crc8(8'h00, c), al), ah);
      a = al[6:0];
      if (c inside {8'hc3, 8'hf0, 8'h0f}) begin
        if (bad_left > 0) begin
          crc = ~crc;
          bad_left--;
        end
        put_byte(crc);
      end
      crc = 8'h00;
      if (c == 8'h0f) begin
        for (int i = 0; i < 8; i++) begin
          get_byte(buf8[i]);
          crc = crc8(crc, buf8[i]);
        end
        put_byte(crc);
        get_byte(c);
        @(posedge vpp);
        if (c == 8'h5a && wp_ok[a/32]) begin
          for (int i = 0; i < 8; i++) mem[a + i] &= buf8[i];
        end
      end else if (c inside {8'hc3, 8'hf0}) begin
        while (a < 128) begin
          put_byte(mem[a]);
          crc = crc8(crc, mem[a]);
          a++;
          if ((c == 8'hc3 && a % 32 == 0) || a == 128) begin
            put_byte(crc);
            crc = 8'h00;
          end
        end
      end
    end
    @(rst_ev);  // line left released: ones until reset
  endtask
  initial begin
    pull_low = 1'b0;
    @(rst_ev);
    forever begin
      fork
        session();
        @(rst_ev);
      join_any
      disable fork;
      pull_low = 1'b0;
    end
  end
endmodule

// File: swh_host_tb_top.sv
// self-checking bench: swh_host driving the behavioural otp memory
// assumes the checker and swh_dev_model.sv are compiled before this file
module swh_host_tb_top
  import swh_pkg::*, swh_vpkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  FAMILY = 8'h5e;  // arbitrary value
  localparam logic [47:0] SERIAL = 48'h2a7d13c04e91;
  localparam logic [55:0] ID     = {SERIAL, FAMILY};
  logic       CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  swh_req_s   req = '0;
  swh_rd_s    rd;
  swh_sts_s   sts;
  logic       req_ready, dq_out, dq_oe, vpp_en, dev_pull;
  logic       dev_on = 1'b1;
  wire        line = !((dq_oe && !dq_out) || (dev_pull && dev_on));
  int         err_total = 0;
  int         checks_done = 0;
  int         seed = 30430;
  logic [7:0] img [128];
  logic [7:0] exp_q [$];
  always #10 CLK = ~CLK;
  // reset, slot and program counts scaled down so the run stays short
  swh_host #(.RST_CYC(200), .PROG_CYC(200), .RETRIES(2), .LOW0_CYC(60), .LOW1_CYC(6),
             .SAMP_CYC(15), .SLOT_CYC(70), .PRES_CYC(70)) dut_u (
    .CLK(CLK), .SYS_RST(SYS_RST), .REQ(req), .REQ_READY(req_ready), .RD(rd), .STS(sts),
    .DQ_IN(line), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .VPP_EN(vpp_en));
  swh_dev_model #(.FAMILY(FAMILY), .SERIAL(SERIAL), .RST_MIN(100), .PRES_WAIT(20),
                  .PRES_LEN(60), .BIT_WAIT(30)) dev_u (
    .clk(CLK), .line(line), .vpp(vpp_en), .pull_low(dev_pull));
  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_flag(string what, logic exp, logic seen);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic run(swh_op_e op, logic [6:0] a, logic exp_fail, logic exp_nop);
    do @(negedge CLK); while (req_ready !== 1'b1);
    @(posedge CLK);
    req <= '{valid: 1'b1, op: op, addr: a, wdata: req.wdata};
    @(posedge CLK);
    req.valid <= 1'b0;
    for (int n = 0; n < 20000; n++) begin
      @(negedge CLK);
      if (rd.valid === 1'b1) chk_byte("read byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rd.data);
      if (sts.done === 1'b1) break;
    end
    chk_flag("done", 1'b1, sts.done);
    chk_flag("crc fail", exp_fail, sts.crc_fail);
    chk_flag("no presence", exp_nop, sts.no_presence);
    chk_byte("bytes left", 8'h00, 8'(exp_q.size()));
    exp_q.delete();
  endtask
  initial begin
    logic [7:0] c;
    foreach (img[i]) img[i] = 8'hff;
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'b0;
    dev_on <= 1'b0;
    run(OP_READ_ID, 7'h00, 1'b0, 1'b1);
    dev_on <= 1'b1;
    c = 8'h00;
    for (int i = 0; i < 7; i++) begin
      exp_q.push_back(ID[8*i +: 8]);
      c = crc8(c, ID[8*i +: 8]);
    end
    exp_q.push_back(c);
    run(OP_READ_ID, 7'h00, 1'b0, 1'b0);
    @(posedge CLK);
    req.wdata <= {$random(seed), $random(seed)};
    run(OP_WRITE, 7'h7d, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) img[8'h78 + i] &= req.wdata[8*i +: 8];
    dev_u.bad_left = 1;
    for (int i = 8'h7c; i < 128; i++) exp_q.push_back(img[i]);
    run(OP_PAGE_READ, 7'h7c, 1'b0, 1'b0);
    dev_u.bad_left = 2;
    run(OP_WRITE, 7'h00, 1'b1, 1'b0);
    exp_q.push_back(img[127]);
    run(OP_FIELD_READ, 7'h7f, 1'b0, 1'b0);
    final_report();
  end
  // about twice the expected length of all six requests
  initial begin
    repeat (70000) @(posedge CLK);
    err_total++;
    final_report();
  end
endmodule
